// >>> verilog/tpc_consts.svh
// Register offsets, field positions and reset values for the timer block
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH
`define TPC_ADDR_W 12
`define TPC_T0_CTL_ADDR 12'hF07
`define TPC_T1_CTL_ADDR 12'hF0F
`define TPC_T0_CNT_ADDR 12'hF00
`define TPC_T1_CNT_ADDR 12'hF08
`define TPC_T0_RLD_ADDR 12'hF02
`define TPC_T1_RLD_ADDR 12'hF0A
`define TPC_T0_PWM_ADDR 12'hF04
`define TPC_T1_PWM_ADDR 12'hF0C
`define TPC_T0_CAP_ADDR 12'hF06
`define TPC_T1_CAP_ADDR 12'hF0E
`define TPC_CTL_RESET 8'h00
`define TPC_RUN_BIT 7
`define TPC_POL_BIT 6
`define TPC_DIV_HI 5
`define TPC_DIV_LO 3
`define TPC_MODE_HI 2
`define TPC_MODE_LO 0
`define TPC_RLD_RESET 8'hFF
`define TPC_NUM_TIMERS 2
`endif

// >>> verilog/tpc_pkg.sv
// Types shared by the timer block
package tpc_pkg;
    // Operating modes, encoded in the low three control bits
    typedef enum logic [2:0] {
        TPC_ONESHOT = 3'h0,
        TPC_CONTINUOUS = 3'h1,
        TPC_COUNTER = 3'h2,
        TPC_PWM = 3'h3,
        TPC_CAPTURE = 3'h4
    } tpc_mode_e;
    // Control byte layout
    typedef struct packed {
        logic timerRunEnable;
        logic outputPolaritySelect;
        logic [2:0] clockDividerSelect;
        logic [2:0] operatingModeSelect;
    } tpc_ctl_s;
    // Register file access strobe group
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [11:0] addr;
        logic [7:0] wrData;
    } tpc_bus_s;
endpackage

// >>> verilog/tpc_timer_core.sv
// One timer channel: prescaler, counter, output and capture logic
`timescale 1ns/100ps
`include "tpc_consts.svh"
module tpc_timer_core import tpc_pkg::*; #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstSync_n,
    // Control and limits
    input tpc_ctl_s ctl,
    input wire logic [CNT_W-1:0] reloadVal,
    input wire logic [CNT_W-1:0] pwmVal,
    input wire logic ctlWritten,
    // Synchronised timer input pin
    input wire logic timerIn,
    // Results
    output logic [CNT_W-1:0] count,
    output logic [CNT_W-1:0] capture,
    output logic timerOut
);
    // Channel state
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] cap;
        logic [6:0] pre;
        logic out;
        logic inPrev;
        logic wasRun;
        logic done;
    } tpc_core_s;
    tpc_core_s st_r;
    tpc_core_s st_nxt;
    logic tick; // Prescaled count enable
    logic edgeSeen; // Selected input edge
    logic atLimit; // Count reached reload value
    tpc_mode_e mode;
    // Prescaler tap: divide by 2**select
    function automatic logic divTap(input logic [6:0] pre,
                                    input logic [2:0] sel);
        logic [7:0] lim;
        lim = 8'h01 << sel;
        divTap = ({1'b0, pre} == (lim - 8'h01));
    endfunction
    // Combinational next state
    always_comb begin
        st_nxt = st_r;
        mode = tpc_mode_e'(ctl.operatingModeSelect);
        tick = divTap(st_r.pre, ctl.clockDividerSelect);
        // Rising edge for polarity 0, falling for 1
        edgeSeen = ctl.outputPolaritySelect ? (st_r.inPrev && !timerIn)
                                            : (!st_r.inPrev && timerIn);
        atLimit = (st_r.cnt == reloadVal);
        st_nxt.inPrev = timerIn;
        st_nxt.wasRun = ctl.timerRunEnable;
        if (ctlWritten && !ctl.timerRunEnable) begin
            st_nxt.done = 1'b0;
        end
        if (!ctl.timerRunEnable) begin
            // Stopped: count frozen, prescaler cleared
            st_nxt.pre = 7'h00;
            if (mode == TPC_PWM) begin
                st_nxt.out = ctl.outputPolaritySelect;
            end else if (mode != TPC_COUNTER) begin
                st_nxt.out = ctl.outputPolaritySelect;
            end
        end else begin
            // Prescaler runs every clock while enabled, except in unused mode codes
            st_nxt.pre = tick ? 7'h00 : st_r.pre + 7'h01;
            unique case (mode)
                TPC_COUNTER: begin
                    if (edgeSeen) begin
                        if (atLimit) begin
                            st_nxt.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
                            st_nxt.out = !st_r.out;
                        end else begin
                            st_nxt.cnt = st_r.cnt + 1'b1;
                        end
                    end
                end
                TPC_CAPTURE: begin
                    if (edgeSeen) begin
                        st_nxt.cap = st_r.cnt;
                    end
                    if (tick) begin
                        st_nxt.cnt = atLimit ? {{(CNT_W-1){1'b0}}, 1'b1}
                                             : st_r.cnt + 1'b1;
                    end
                end
                TPC_PWM: begin
                    if (tick) begin
                        if (atLimit) begin
                            st_nxt.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
                            st_nxt.out = ctl.outputPolaritySelect;
                        end else begin
                            st_nxt.cnt = st_r.cnt + 1'b1;
                            if (st_r.cnt + 1'b1 == pwmVal) begin
                                st_nxt.out = !ctl.outputPolaritySelect;
                            end
                        end
                    end
                end
                TPC_ONESHOT: begin
                    if (tick && !st_r.done) begin
                        if (atLimit) begin
                            st_nxt.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
                            st_nxt.out = !st_r.out;
                            st_nxt.done = 1'b1;
                        end else begin
                            st_nxt.cnt = st_r.cnt + 1'b1;
                        end
                    end
                end
                TPC_CONTINUOUS: begin
                    if (tick) begin
                        if (atLimit) begin
                            st_nxt.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
                            st_nxt.out = !st_r.out;
                        end else begin
                            st_nxt.cnt = st_r.cnt + 1'b1;
                        end
                    end
                end
                default: begin
                    // Unused mode codes hold the channel
                    st_nxt.pre = st_r.pre;
                end
            endcase
        end
    end
    // State register
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign count = st_r.cnt;
    assign capture = st_r.cap;
    assign timerOut = st_r.out;
endmodule

// >>> verilog/tpc_timer_block.sv
// Two-timer block with control registers on the register file port
//
// Overview of operation
// - Timer counts only while run enable is set.
// - Control byte: run bit7, polarity bit6, fields.
// - One-shot/continuous: idle output equals polarity, toggles.
// - Counter mode toggles output after each reload.
// - Counter counts rising edge, or falling if polarity.
// - PWM polarity 0: idle low, match high.
// - PWM polarity 1: idle high, match low.
// - Capture polarity 0 captures on rising edge.
// - Capture polarity 1 captures on falling edge.
// - Two timers, control bytes at F07 and F0F.
`timescale 1ns/100ps
`include "tpc_consts.svh"
module tpc_timer_block import tpc_pkg::*; #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register file port
    input tpc_bus_s bus,
    output logic [7:0] rdData,
    // Timer pins
    input wire logic [1:0] timerInPin,
    output logic [1:0] timerOutPin
);
    // Block state
    typedef struct packed {
        tpc_ctl_s [1:0] ctl;
        logic [1:0][CNT_W-1:0] rld;
        logic [1:0][CNT_W-1:0] pwm;
        logic [1:0] ctlWr;
        logic [7:0] rd;
        logic [1:0] out;
    } tpc_top_s;
    tpc_top_s st_r;
    tpc_top_s st_nxt;
    logic [1:0] rstSync; // Reset release stages
    logic rstSync_n; // Released reset
    logic [1:0] inMeta; // First synchroniser stage
    logic [1:0] inSync; // Second synchroniser stage
    logic [1:0][CNT_W-1:0] cnt; // Live counts
    logic [1:0][CNT_W-1:0] cap; // Captured counts
    logic [1:0] coreOut; // Core outputs
    // Elaboration check on counter width
    if (CNT_W < 2 || CNT_W > 8) begin : gBadWidth
        $error("CNT_W must be 2 to 8");
    end
    // Address of a timer register: channel 0 base or channel 1 base
    function automatic logic [11:0] regAddr(input logic [11:0] base0,
                                            input logic [11:0] base1,
                                            input int ch);
        regAddr = (ch == 0) ? base0 : base1;
    endfunction
    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstSync_n = rstSync[1];
    // Pin input synchroniser
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            inMeta <= 2'h0;
            inSync <= 2'h0;
        end else begin
            inMeta <= timerInPin;
            inSync <= inMeta;
        end
    end
    // Register writes and reads
    always_comb begin
        st_nxt = st_r;
        st_nxt.ctlWr = 2'h0;
        st_nxt.rd = 8'h00;
        st_nxt.out = coreOut;
        for (int i = 0; i < `TPC_NUM_TIMERS; i++) begin
            if (bus.wrEn) begin
                if (bus.addr == regAddr(`TPC_T0_CTL_ADDR,
                                        `TPC_T1_CTL_ADDR, i)) begin
                    st_nxt.ctl[i] = tpc_ctl_s'(bus.wrData);
                    st_nxt.ctlWr[i] = 1'b1;
                end
                if (bus.addr == regAddr(`TPC_T0_RLD_ADDR,
                                        `TPC_T1_RLD_ADDR, i)) begin
                    st_nxt.rld[i] = bus.wrData[CNT_W-1:0];
                end
                if (bus.addr == regAddr(`TPC_T0_PWM_ADDR,
                                        `TPC_T1_PWM_ADDR, i)) begin
                    st_nxt.pwm[i] = bus.wrData[CNT_W-1:0];
                end
            end
            if (bus.rdEn) begin
                if (bus.addr == regAddr(`TPC_T0_CTL_ADDR,
                                        `TPC_T1_CTL_ADDR, i)) begin
                    st_nxt.rd = st_r.ctl[i];
                end
                if (bus.addr == regAddr(`TPC_T0_CNT_ADDR,
                                        `TPC_T1_CNT_ADDR, i)) begin
                    st_nxt.rd = 8'(cnt[i]);
                end
                if (bus.addr == regAddr(`TPC_T0_RLD_ADDR,
                                        `TPC_T1_RLD_ADDR, i)) begin
                    st_nxt.rd = 8'(st_r.rld[i]);
                end
                if (bus.addr == regAddr(`TPC_T0_PWM_ADDR,
                                        `TPC_T1_PWM_ADDR, i)) begin
                    st_nxt.rd = 8'(st_r.pwm[i]);
                end
                if (bus.addr == regAddr(`TPC_T0_CAP_ADDR,
                                        `TPC_T1_CAP_ADDR, i)) begin
                    st_nxt.rd = 8'(cap[i]);
                end
            end
        end
    end
    // State register, control bytes clear to zero
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            st_r <= '0;
            st_r.rld <= {2{CNT_W'(`TPC_RLD_RESET)}};
        end else begin
            st_r <= st_nxt;
        end
    end
    // Two independent channels
    for (genvar g = 0; g < `TPC_NUM_TIMERS; g++) begin : gTimer
        tpc_timer_core #(.CNT_W(CNT_W)) uCore (
            .clk(clk),
            .rstSync_n(rstSync_n),
            .ctl(st_r.ctl[g]),
            .reloadVal(st_r.rld[g]),
            .pwmVal(st_r.pwm[g]),
            .ctlWritten(st_r.ctlWr[g]),
            .timerIn(inSync[g]),
            .count(cnt[g]),
            .capture(cap[g]),
            .timerOut(coreOut[g])
        );
    end
    assign rdData = st_r.rd;
    assign timerOutPin = st_r.out;
endmodule

// >>> tb/tpc_timer_block_sva.sv
// Port-level checker for the two-timer block
`timescale 1ns/100ps
module tpc_timer_block_chk import tpc_pkg::*; #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input tpc_bus_s bus,
    input wire logic [7:0] rdData,
    // Timer pins
    input wire logic [1:0] timerInPin,
    input wire logic [1:0] timerOutPin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    tpc_ctl_s ctl_r [2]; // Shadow control bytes
    logic [3:0] quiet_r [2]; // Cycles since last control write
    logic [1:0] idle; // Timer stopped and settled
    logic mapped; // Address hits a register
    // Settled-idle flags and address decode
    always_comb begin
        idle[0] = !ctl_r[0].timerRunEnable && quiet_r[0] > 4'h4;
        idle[1] = !ctl_r[1].timerRunEnable && quiet_r[1] > 4'h4;
        mapped = bus.addr[11:4] == 8'hF0
            && (!bus.addr[0] || bus.addr[2:0] == 3'h7);
    end
    // Follow control writes, count quiet cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r <= '{default: '0};
            quiet_r <= '{default: '0};
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (bus.wrEn && bus.addr == 12'hF07 + 12'(i * 8)) begin
                    ctl_r[i] <= bus.wrData;
                    quiet_r[i] <= 4'h0;
                end else if (quiet_r[i] != 4'hF) begin
                    quiet_r[i] <= quiet_r[i] + 4'h1;
                end
            end
        end
    end
    a_unmapped_read_zero: assert property (
        bus.rdEn && !mapped |=> rdData == 8'h00)
        else $error("unmapped read gave data");
    a_ctl0_read_back: assert property (
        bus.rdEn && !bus.wrEn && bus.addr == 12'hF07 |=> rdData == ctl_r[0])
        else $error("control 0 read mismatch");
    a_ctl1_read_back: assert property (
        bus.rdEn && !bus.wrEn && bus.addr == 12'hF0F |=> rdData == ctl_r[1])
        else $error("control 1 read mismatch");
    a_t0_idle_level: assert property (
        idle[0] && ctl_r[0].operatingModeSelect < 3'h2
        |-> timerOutPin[0] == ctl_r[0].outputPolaritySelect)
        else $error("timer 0 idle level wrong");
    a_t1_idle_level: assert property (
        idle[1] && ctl_r[1].operatingModeSelect < 3'h2
        |-> timerOutPin[1] == ctl_r[1].outputPolaritySelect)
        else $error("timer 1 idle level wrong");
    a_t0_pwm_idle: assert property (
        idle[0] && ctl_r[0].operatingModeSelect == 3'h3
        |-> timerOutPin[0] == ctl_r[0].outputPolaritySelect)
        else $error("timer 0 pwm idle level wrong");
    a_t1_pwm_idle: assert property (
        idle[1] && ctl_r[1].operatingModeSelect == 3'h3
        |-> timerOutPin[1] == ctl_r[1].outputPolaritySelect)
        else $error("timer 1 pwm idle level wrong");
    a_t0_stopped_hold: assert property (
        idle[0] |=> $stable(timerOutPin[0]))
        else $error("timer 0 output moved while stopped");
    a_t1_stopped_hold: assert property (
        idle[1] |=> $stable(timerOutPin[1]))
        else $error("timer 1 output moved while stopped");
    c_unmapped: cover property (bus.rdEn && !mapped);
    c_pwm_high: cover property (ctl_r[0] == 8'h83 && timerOutPin[0]);
    c_capture_edge: cover property (ctl_r[1] == 8'hC4 && $fell(timerInPin[1]));
endmodule

bind tpc_timer_block tpc_timer_block_chk #(.CNT_W(CNT_W)) u_chk (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdData(rdData),
    .timerInPin(timerInPin), .timerOutPin(timerOutPin));

// >>> tb/tpc_pin_source.sv
// Model of the external source driving the timer input pins
`timescale 1ns/100ps
module tpc_pin_source (
    // Clock
    input wire logic clk,
    // Requested levels and pacing
    input wire logic [1:0] wantLevel,
    input wire logic slow,
    // Levels on the pins
    output logic [1:0] pinLevel = 2'b00
);
    logic [1:0] stage_r = 2'b00; // Extra stage for a slow source
    // Follow the request one or two edges later
    always @(posedge clk) begin
        stage_r <= wantLevel;
        pinLevel <= slow ? stage_r : wantLevel;
    end
endmodule

// >>> tb/testbench.sv
// Self-checking testbench for the two-timer block
`timescale 1ns/100ps
module testbench import tpc_pkg::*; ();
    logic clk; // System clock
    logic rst_n = 1'b0; // Active-low reset
    tpc_bus_s bus = '0; // Register port request
    logic [7:0] rdData; // Read data
    logic [1:0] timerInPin; // Input pins
    logic [1:0] timerOutPin; // Output pins
    logic [1:0] wantLevel = 2'b00; // Requested input levels
    logic slow = 1'b0; // Source pacing
    logic [1:0] lastOut = 2'b00; // Outputs at previous edge
    int outEdges [2] = '{0, 0}; // Output transitions per timer
    int errors = 0; // Mismatches
    int checks_done = 0; // Comparisons
    // Block under test
    tpc_timer_block #(.CNT_W(8)) u_dut (.clk(clk), .rst_n(rst_n), .bus(bus),
        .rdData(rdData), .timerInPin(timerInPin), .timerOutPin(timerOutPin));
    // Signal source on the input pins
    tpc_pin_source u_src (.clk(clk), .wantLevel(wantLevel), .slow(slow),
        .pinLevel(timerInPin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Count output transitions
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (timerOutPin[i] !== lastOut[i]) outEdges[i]++;
        end
        lastOut <= timerOutPin;
    end
    function automatic logic [11:0] ra(input int t, input int o);
        return 12'hF00 + 12'(t * 8 + o);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        bus = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
        @(negedge clk);
        bus = '0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(negedge clk);
        bus = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
        @(negedge clk);
        d = rdData;
        bus = '0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] x);
        logic [7:0] d;
        rd(a, d);
        chk(d, x);
    endtask
    task automatic level(input int t, input logic v);
        @(negedge clk);
        wantLevel[t] = v;
        cyc(8);
    endtask
    task automatic t_regs();
        rdchk(ra(0, 7), 8'h00);
        rdchk(ra(1, 7), 8'h00);
        wr(12'hF01, 8'h5A);
        rdchk(12'hF01, 8'h00);
    endtask
    task automatic t_run(input int t, input logic [7:0] c, input int s,
        input int n, input int x);
        int e0;
        int e1;
        logic [7:0] a;
        wr(ra(t, 2), 8'h03);
        wr(ra(t, 7), c);
        cyc(s);
        e0 = outEdges[t];
        e1 = outEdges[1 - t];
        cyc(n);
        chk(8'(outEdges[t] - e0), 8'(x));
        chk(8'(outEdges[1 - t] - e1), 8'h00);
        wr(ra(t, 7), c & 8'h7F);
        cyc(5);
        chk({7'h00, timerOutPin[t]}, {7'h00, c[6]});
        rd(ra(t, 0), a);
        cyc(4);
        rdchk(ra(t, 0), a);
    endtask
    task automatic t_modes();
        logic [7:0] c;
        for (int t = 0; t < 2; t++) begin
            wr(ra(t, 7), 8'hFF);
            rdchk(ra(t, 7), 8'hFF);
            for (int m = 0; m < 10; m++) begin
                c = 8'(m / 2) | (m[0] ? 8'h40 : 8'h00);
                wr(ra(t, 7), c);
                rdchk(ra(t, 7), c);
                cyc(5);
                if (c[2:0] inside {3'h0, 3'h1, 3'h3})
                    chk({7'h00, timerOutPin[t]}, 8'(m[0]));
            end
            wr(ra(t, 7), 8'h00);
        end
    endtask
    task automatic t_pwm(input int t);
        int h [2];
        wr(ra(t, 2), 8'h08);
        wr(ra(t, 4), 8'h04);
        for (int p = 0; p < 2; p++) begin
            wr(ra(t, 7), p ? 8'hC3 : 8'h83);
            cyc(6);
            h[p] = 0;
            repeat (16) begin
                @(negedge clk);
                h[p] += timerOutPin[t];
            end
        end
        wr(ra(t, 7), 8'h00);
        chk(8'(h[0] + h[1]), 8'h10);
        chk(8'(h[0] > 0 && h[0] < 16), 8'h01);
    endtask
    task automatic t_counter(input int t, input logic p);
        logic [7:0] a;
        int e;
        slow = (t == 1);
        wr(ra(t, 2), 8'h02);
        // Run continuous first so the count wraps back to 1..reload
        wr(ra(t, 7), 8'h81);
        cyc(260);
        wr(ra(t, 7), p ? 8'hC2 : 8'h82);
        cyc(6);
        rd(ra(t, 0), a);
        level(t, 1'b1);
        rdchk(ra(t, 0), p ? a : (a == 8'h02 ? 8'h01 : a + 8'h01));
        rd(ra(t, 0), a);
        level(t, 1'b0);
        rdchk(ra(t, 0), !p ? a : (a == 8'h02 ? 8'h01 : a + 8'h01));
        e = outEdges[t];
        repeat (4) begin
            level(t, 1'b1);
            level(t, 1'b0);
        end
        chk(8'(outEdges[t] - e), 8'h02);
        wr(ra(t, 7), 8'h00);
    endtask
    task automatic t_capture(input int t, input logic p);
        logic [7:0] a;
        logic [7:0] b;
        wr(ra(t, 2), 8'hFF);
        wr(ra(t, 7), p ? 8'hC4 : 8'h84);
        level(t, p);
        level(t, !p);
        rd(ra(t, 6), a);
        level(t, p);
        rdchk(ra(t, 6), a);
        level(t, !p);
        rd(ra(t, 6), b);
        chk({7'h00, b !== a}, 8'h01);
        wr(ra(t, 7), 8'h00);
        level(t, 1'b0);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        cyc(4);
        t_regs();
        t_run(0, 8'h80, 0, 24, 1);
        t_run(0, 8'hC1, 4, 12, 4);
        t_run(1, 8'h81, 4, 12, 4);
        t_run(1, 8'h89, 4, 24, 4);
        t_modes();
        for (int t = 0; t < 2; t++) begin
            t_pwm(t);
            t_counter(t, 1'b0);
            t_counter(t, 1'b1);
            t_capture(t, 1'b0);
            t_capture(t, 1'b1);
        end
        complete_run();
    end
    // Cut a hang short
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule
